/* File: include/bit_ctrl_defs.vh */
`ifndef BIT_CTRL_DEFS_VH
`define BIT_CTRL_DEFS_VH

// register byte offsets on the avalon slave
`define OFS_CTRL 4'h0
`define OFS_PC 4'h4
`define OFS_STATUS 4'h8
`define OFS_STACK_TOP 4'hc

// control register fields
`define CTRL_RUN_BIT 0
`define CTRL_PRESC_BIT 1
`define CTRL_C_BIT 4
`define CTRL_Z_BIT 5
`define CTRL_OV_BIT 6
`define CTRL_N_BIT 7
`define CTRL_RESET 8'h00

// status register fields
`define STAT_TIMEOUT_BIT 8
`define STAT_POWERDOWN_BIT 9
`define STAT_HIGH_IRQ_EN_BIT 10
`define STAT_LOW_IRQ_EN_BIT 11
`define STAT_SLEEP_BIT 12
`define STAT_DEPTH_LSB 16

// reset values
`define PC_RESET 20'h00000
`define WORKING_REG_RESET 8'h00

// opcode fields
`define OP_BIT_CLEAR 4'h9
`define OP_BIT_SET 4'h8
`define OP_BIT_TOGGLE 4'h7
`define OP_SKIP_CLEAR 4'hb
`define OP_SKIP_SET 4'ha
`define OP_BRANCH_GRP 4'he
`define OP_REL_GRP 4'hd
`define OP_EXT_WORD 4'hf
`define OP_LIT_RET_HI 8'h0c
`define OP_CALL_HI 7'h76
`define OP_JUMP_HI 8'hef
`define OP_SLEEP 16'h0003
`define OP_PUSH 16'h0005
`define OP_POP 16'h0006
`define OP_IRQ_RET_HI 15'h0008

`endif

/* File: core/return_stack.v */
`timescale 1ns/100ps
`default_nettype none

// hardware return stack, shift style; push when full drops the oldest entry
module return_stack #(
  parameter WIDTH = 20,
  parameter DEPTH = 31,
  parameter CNT_W = 5
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_push,
  input wire i_pop,
  input wire [WIDTH-1:0] i_data,
  output wire [WIDTH-1:0] o_top,
  output wire [CNT_W-1:0] o_depth
);

  // chain: field 0 is the pushed word, 1..DEPTH the slots, DEPTH+1 a constant zero
  wire [WIDTH*(DEPTH+2)-1:0] chain;
  reg [CNT_W-1:0] depth_q;

  assign chain[WIDTH-1:0] = i_data;
  // the field past the last slot is zero so a pop shifts in zero
  assign chain[WIDTH*(DEPTH+2)-1:WIDTH*(DEPTH+1)] = {WIDTH{1'b0}};
  assign o_top = chain[2*WIDTH-1:WIDTH];
  assign o_depth = depth_q;

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_entry
      reg [WIDTH-1:0] slot_q;
      assign chain[WIDTH*(gi+1) +: WIDTH] = slot_q;
      // each slot takes its lower neighbour on push, its upper one on pop
      always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          slot_q <= {WIDTH{1'b0}};
        end else if (i_push) begin
          slot_q <= chain[WIDTH*gi +: WIDTH];
        end else if (i_pop) begin
          slot_q <= chain[WIDTH*(gi+2) +: WIDTH];
        end
      end
    end
  endgenerate

  // occupancy count, saturating at both ends
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      depth_q <= {CNT_W{1'b0}};
    end else if (i_push && depth_q != DEPTH[CNT_W-1:0]) begin
      depth_q <= depth_q + 1'b1;
    end else if (i_pop && !i_push && depth_q != {CNT_W{1'b0}}) begin
      depth_q <= depth_q - 1'b1;
    end
  end

endmodule // return_stack

`default_nettype wire

/* File: core/bit_and_control_op_decoder.v */
// Behaviour
// - clear/set/toggle bit; ports read pin levels
// - skip next word when tested bit clear
// - skip next word when tested bit set
// - branch on zero/carry/overflow and their inverses
// - branch on negative or not negative
// - pc change or skip adds no-op cycle
// - two-word call pushes return, jumps absolute
// - two-word absolute jump
// - lone extension word executes as no-op
// - pop discards return stack top, one cycle
// - push stores address of the next word, one cycle
// - interrupt return pops, re-enables interrupt bits
// - literal return loads working register, returns
// - sleep enters standby, updates timeout/powerdown
// - bit op on timer zero clears prescaler
//
// Implementation choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "bit_ctrl_defs.vh"

module bit_and_control_op_decoder #(
  parameter PC_W = 20,
  parameter STACK_DEPTH = 31,
  parameter STACK_CNT_W = 5,
  parameter [8:0] TIMER0_ADDR = 9'h0d6
) (
  input wire i_clk,
  input wire i_rst_n,
  // program memory, read combinationally at o_pm_addr
  output wire [PC_W-1:0] o_pm_addr,
  input wire [15:0] i_pm_data,
  // file register read port
  output wire [8:0] o_file_raddr,
  input wire [7:0] i_file_rdata,
  input wire i_file_is_port,
  input wire [7:0] i_pin_data,
  // file register write port
  output reg o_file_we,
  output reg [8:0] o_file_waddr,
  output reg [7:0] o_file_wdata,
  output reg o_prescaler_clr,
  input wire i_wake,
  // avalon-mm slave
  input wire [3:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output wire o_avs_waitrequest
);

  localparam [3:0] S_EXEC = 4'b0001;
  localparam [3:0] S_FLUSH = 4'b0010;
  localparam [3:0] S_OPER = 4'b0100;
  localparam [3:0] S_SLEEP = 4'b1000;

  reg [3:0] state_q, state_d;
  reg [PC_W-1:0] pc_q, pc_d;
  reg [7:0] ctrl_q;
  reg [7:0] working_register_q, working_register_d;
  reg timeout_q, timeout_d;
  reg powerdown_q, powerdown_d;
  reg global_high_irq_enable_q, global_high_irq_enable_d;
  reg peripheral_low_irq_enable_q, peripheral_low_irq_enable_d;
  reg skip_q, skip_d;
  reg is_call_q, is_call_d;
  reg [7:0] k_lo_q, k_lo_d;
  reg ack_q;
  reg push, pop;
  reg [PC_W-1:0] push_data;
  reg we_d;
  reg [7:0] wdata_d;
  reg presc_d;
  reg cond_true;
  wire [PC_W-1:0] stack_top;
  wire [STACK_CNT_W-1:0] stack_depth;
  wire [15:0] w = i_pm_data;
  wire [3:0] top4 = w[15:12];
  wire [PC_W-1:0] pc_inc = pc_q + 1'b1;
  wire [PC_W-1:0] br8 = pc_inc + {{(PC_W-8){w[7]}}, w[7:0]};
  wire [PC_W-1:0] br11 = pc_inc + {{(PC_W-11){w[10]}}, w[10:0]};
  wire run = ctrl_q[`CTRL_RUN_BIT];
  wire [7:0] bit_mask = 8'h01 << w[11:9];
  // ports read back pin levels, other files the stored value
  wire [7:0] rmw_src = i_file_is_port ? i_pin_data : i_file_rdata;
  wire bit_val = |(rmw_src & bit_mask);
  wire acc = i_avs_read | i_avs_write;
  wire [31:0] be_mask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                         {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  wire [31:0] pc_word = {{(32-PC_W){1'b0}}, pc_q};
  wire [31:0] pc_merge = (pc_word & ~be_mask) | (i_avs_writedata & be_mask);
  wire [31:0] status_word;

  assign o_pm_addr = pc_q;
  assign o_file_raddr = {w[8], w[7:0]};
  assign o_avs_waitrequest = acc & ~ack_q;
  assign status_word = {{(16-STACK_CNT_W){1'b0}}, stack_depth, 3'h0, state_q[3],
                        peripheral_low_irq_enable_q, global_high_irq_enable_q,
                        powerdown_q, timeout_q, working_register_q};

  return_stack #(
    .WIDTH(PC_W),
    .DEPTH(STACK_DEPTH),
    .CNT_W(STACK_CNT_W)
  ) u_stack (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_push(push),
    .i_pop(pop),
    .i_data(push_data),
    .o_top(stack_top),
    .o_depth(stack_depth)
  );

  // branch condition from the flag bits held in control
  always @* begin
    case (w[10:8])
      3'd0: cond_true = ctrl_q[`CTRL_Z_BIT];
      3'd1: cond_true = ~ctrl_q[`CTRL_Z_BIT];
      3'd2: cond_true = ctrl_q[`CTRL_C_BIT];
      3'd3: cond_true = ~ctrl_q[`CTRL_C_BIT];
      3'd4: cond_true = ctrl_q[`CTRL_OV_BIT];
      3'd5: cond_true = ~ctrl_q[`CTRL_OV_BIT];
      3'd6: cond_true = ctrl_q[`CTRL_N_BIT];
      default: cond_true = ~ctrl_q[`CTRL_N_BIT];
    endcase
  end

  // instruction sequencer: one clock per instruction cycle
  always @* begin
    state_d = state_q;
    pc_d = pc_q;
    working_register_d = working_register_q;
    timeout_d = timeout_q;
    powerdown_d = powerdown_q;
    global_high_irq_enable_d = global_high_irq_enable_q;
    peripheral_low_irq_enable_d = peripheral_low_irq_enable_q;
    skip_d = 1'b0;
    is_call_d = is_call_q;
    k_lo_d = k_lo_q;
    push = 1'b0;
    pop = 1'b0;
    push_data = pc_inc;
    we_d = 1'b0;
    wdata_d = 8'h00;
    presc_d = 1'b0;
    if (run) begin
      case (state_q)
        S_EXEC: begin
          pc_d = pc_inc;
          if (skip_q) begin
            // skipped word runs as a no-op; a following extension word is one too
            pc_d = pc_inc;
          end else if (top4 == `OP_BIT_CLEAR || top4 == `OP_BIT_SET ||
                       top4 == `OP_BIT_TOGGLE) begin
            we_d = 1'b1;
            if (top4 == `OP_BIT_CLEAR) begin
              wdata_d = rmw_src & ~bit_mask;
            end else if (top4 == `OP_BIT_SET) begin
              wdata_d = rmw_src | bit_mask;
            end else begin
              wdata_d = rmw_src ^ bit_mask;
            end
            presc_d = ({w[8], w[7:0]} == TIMER0_ADDR) && ctrl_q[`CTRL_PRESC_BIT];
          end else if (top4 == `OP_SKIP_CLEAR) begin
            skip_d = ~bit_val;
          end else if (top4 == `OP_SKIP_SET) begin
            skip_d = bit_val;
          end else if (top4 == `OP_BRANCH_GRP && !w[11]) begin
            if (cond_true) begin
              pc_d = br8;
              state_d = S_FLUSH;
            end
          end else if (top4 == `OP_BRANCH_GRP && w[15:9] == `OP_CALL_HI) begin
            k_lo_d = w[7:0];
            is_call_d = 1'b1;
            state_d = S_OPER;
          end else if (top4 == `OP_BRANCH_GRP && w[15:8] == `OP_JUMP_HI) begin
            k_lo_d = w[7:0];
            is_call_d = 1'b0;
            state_d = S_OPER;
          end else if (top4 == `OP_REL_GRP) begin
            if (w[11]) begin
              push = 1'b1;
            end
            pc_d = br11;
            state_d = S_FLUSH;
          end else if (top4 == `OP_EXT_WORD) begin
            pc_d = pc_inc;
          end else if (w == `OP_POP) begin
            pop = 1'b1;
          end else if (w == `OP_PUSH) begin
            push = 1'b1;
          end else if (w[15:1] == `OP_IRQ_RET_HI) begin
            pop = 1'b1;
            pc_d = stack_top;
            global_high_irq_enable_d = 1'b1;
            peripheral_low_irq_enable_d = 1'b1;
            state_d = S_FLUSH;
          end else if (w[15:8] == `OP_LIT_RET_HI) begin
            working_register_d = w[7:0];
            pop = 1'b1;
            pc_d = stack_top;
            state_d = S_FLUSH;
          end else if (w == `OP_SLEEP) begin
            timeout_d = 1'b0;
            powerdown_d = 1'b1;
            state_d = S_SLEEP;
          end
        end
        S_OPER: begin
          // second word supplies the upper twelve address bits
          pc_d = {w[PC_W-9:0], k_lo_q};
          push = is_call_q;
          push_data = pc_inc;
          state_d = S_EXEC;
        end
        S_FLUSH: begin
          state_d = S_EXEC;
        end
        default: begin
          if (i_wake) begin
            state_d = S_EXEC;
          end
        end
      endcase
    end
  end

  // sequencer state, with software writes to the pc taking priority
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= S_EXEC;
      pc_q <= `PC_RESET;
      working_register_q <= `WORKING_REG_RESET;
      timeout_q <= 1'b0;
      powerdown_q <= 1'b0;
      global_high_irq_enable_q <= 1'b0;
      peripheral_low_irq_enable_q <= 1'b0;
      skip_q <= 1'b0;
      is_call_q <= 1'b0;
      k_lo_q <= 8'h00;
    end else begin
      state_q <= state_d;
      working_register_q <= working_register_d;
      timeout_q <= timeout_d;
      powerdown_q <= powerdown_d;
      global_high_irq_enable_q <= global_high_irq_enable_d;
      peripheral_low_irq_enable_q <= peripheral_low_irq_enable_d;
      is_call_q <= is_call_d;
      k_lo_q <= k_lo_d;
      if (run) begin
        skip_q <= skip_d;
      end
      if (i_avs_write && ack_q && i_avs_address == `OFS_PC) begin
        pc_q <= pc_merge[PC_W-1:0];
      end else begin
        pc_q <= pc_d;
      end
    end
  end

  // registered file write port and prescaler clear pulse
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_file_we <= 1'b0;
      o_file_waddr <= 9'h000;
      o_file_wdata <= 8'h00;
      o_prescaler_clr <= 1'b0;
    end else begin
      o_file_we <= we_d;
      o_file_waddr <= {w[8], w[7:0]};
      o_file_wdata <= wdata_d;
      o_prescaler_clr <= presc_d;
    end
  end

  // avalon slave: one wait cycle, read data captured in that cycle
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_q <= 1'b0;
      ctrl_q <= `CTRL_RESET;
      o_avs_readdata <= 32'h00000000;
    end else begin
      ack_q <= acc & ~ack_q;
      if (i_avs_read && !ack_q) begin
        if (i_avs_address == `OFS_CTRL) begin
          o_avs_readdata <= {24'h000000, ctrl_q};
        end else if (i_avs_address == `OFS_PC) begin
          o_avs_readdata <= pc_word;
        end else if (i_avs_address == `OFS_STATUS) begin
          o_avs_readdata <= status_word;
        end else if (i_avs_address == `OFS_STACK_TOP) begin
          o_avs_readdata <= {{(32-PC_W){1'b0}}, stack_top};
        end else begin
          o_avs_readdata <= 32'h00000000;
        end
      end
      if (i_avs_write && ack_q && i_avs_address == `OFS_CTRL && i_avs_byteenable[0]) begin
        ctrl_q <= i_avs_writedata[7:0];
      end
    end
  end

endmodule // bit_and_control_op_decoder

`default_nettype wire

/* File: verification/bit_and_control_op_decoder_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
// port-level checks on bit writes and the bus handshake
module bit_and_control_op_decoder_asserts #(
  parameter [8:0] TIMER0_ADDR = 9'h0d6
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [15:0] i_pm_data,
  input wire logic [8:0] o_file_raddr,
  input wire logic [7:0] i_file_rdata,
  input wire logic i_file_is_port,
  input wire logic [7:0] i_pin_data,
  input wire logic o_file_we,
  input wire logic [8:0] o_file_waddr,
  input wire logic [7:0] o_file_wdata,
  input wire logic o_prescaler_clr,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // source byte, mask and the three results for the word at the core
  wire logic [3:0] op = i_pm_data[15:12];
  wire logic [7:0] src = i_file_is_port ? i_pin_data : i_file_rdata;
  wire logic [7:0] msk = 8'h01 << i_pm_data[11:9];
  wire logic [7:0] set_v = src | msk;
  wire logic [7:0] clr_v = src & ~msk;
  wire logic [7:0] tog_v = src ^ msk;
  wire logic req = i_avs_read | i_avs_write;
  chk_set_value: assert property (o_file_we && $past(op) == 4'h8 |->
    o_file_wdata == $past(set_v)) else $error("bit set value wrong");
  chk_clear_value: assert property (o_file_we && $past(op) == 4'h9 |->
    o_file_wdata == $past(clr_v)) else $error("bit clear value wrong");
  chk_toggle_value: assert property (o_file_we && $past(op) == 4'h7 |->
    o_file_wdata == $past(tog_v)) else $error("bit toggle value wrong");
  chk_write_addr: assert property (o_file_we |-> o_file_waddr == $past(o_file_raddr))
    else $error("write address wrong");
  chk_write_cause: assert property (o_file_we |-> $past(op) inside {4'h7, 4'h8, 4'h9})
    else $error("write without bit op");
  chk_read_addr: assert property (op inside {4'h7, 4'h8, 4'h9, 4'ha, 4'hb} |->
    o_file_raddr == i_pm_data[8:0]) else $error("file read address wrong");
  chk_presc_target: assert property (o_prescaler_clr |->
    o_file_we && o_file_waddr == TIMER0_ADDR) else $error("prescaler clear misplaced");
  chk_wait_first: assert property ($rose(req) |-> o_avs_waitrequest)
    else $error("no wait cycle");
  chk_wait_one: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("wait longer than one cycle");
  chk_wait_idle: assert property (!req |-> !o_avs_waitrequest)
    else $error("wait without request");
  cover property (o_prescaler_clr);
  cover property (o_file_we && i_file_is_port);
  cover property (req && !o_avs_waitrequest);
endmodule // bit_and_control_op_decoder_asserts
`default_nettype wire

/* File: verification/prog_mem.sv */
`timescale 1ns/100ps
`default_nettype none
// program memory, read combinationally; bench fills words while the core is in reset, halted or in standby
module prog_mem (
  input wire logic [19:0] i_addr,
  output logic [15:0] o_data
);
  logic [15:0] mem [0:15];
  // words past the table read as no-op
  assign o_data = (i_addr < 20'h00010) ? mem[i_addr[3:0]] : 16'h0000;
endmodule // prog_mem
`default_nettype wire

/* File: verification/test_bit_and_control_op_decoder.sv */
`timescale 1ns/100ps
`default_nettype none
module test_bit_and_control_op_decoder;
  logic i_clk = 0, rst_n = 0, rd = 0, wr = 0, wake = 0, port = 0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 0, rdat, st, r, seed = 32'h234400b4;
  logic [7:0] fd = 0, pin_lvl = 0, c, lwd;
  logic [3:0] be = 4'hf;
  logic [15:0] w;
  logic [8:0] lwa;
  wire [19:0] pa;
  wire [15:0] pw;
  wire [8:0] fa, wa;
  wire [7:0] wdt;
  wire we, pz, wq;
  wire [31:0] rq;
  int n_mismatch = 0, tests_run = 0, cyc = 0, nwe, npz, k, j;
  bit_and_control_op_decoder u_bit_and_control_op_decoder (.i_clk(i_clk), .i_rst_n(rst_n),
    .o_pm_addr(pa), .i_pm_data(pw), .o_file_raddr(fa), .i_file_rdata(fd),
    .i_file_is_port(port), .i_pin_data(pin_lvl), .o_file_we(we), .o_file_waddr(wa),
    .o_file_wdata(wdt), .o_prescaler_clr(pz), .i_wake(wake), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
    .o_avs_readdata(rq), .o_avs_waitrequest(wq));
  prog_mem u_prog_mem (.i_addr(pa), .o_data(pw));
  // clock and hang guard
  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) if (++cyc == 8000) begin
    n_mismatch++;
    summarize();
  end
  // counts write and prescaler pulses between edges
  always @(negedge i_clk) begin
    if (we) begin
      nwe++;
      lwd = wdt;
      lwa = wa;
    end
    if (pz) npz++;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // expected branch decision, fl is {n, ov, z, c}
  function automatic logic taken(input logic [2:0] cc, input logic [3:0] fl);
    logic t;
    case (cc[2:1])
      2'd0: t = fl[1];
      2'd1: t = fl[0];
      2'd2: t = fl[2];
      default: t = fl[3];
    endcase
    return t ^ cc[0];
  endfunction
  function automatic logic [7:0] bitop(input logic [3:0] op, input logic [7:0] s,
      input logic [2:0] b);
    logic [7:0] m;
    m = 8'h01 << b;
    return op == 4'h9 ? s & ~m : op == 4'h8 ? s | m : s ^ m;
  endfunction
  task chk(input logic [31:0] s, input logic [31:0] e, input string n);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // one avalon access, held until waitrequest is seen low at a rising edge
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge i_clk);
    while (wq !== 1'b0) @(posedge i_clk);
    rdat = rq;
    rd <= 0;
    wr <= 0;
  endtask
  task prog(input logic [15:0] w0, w1, w2, w3, input int ta, input logic [15:0] tw);
    for (int i = 0; i < 16; i++) u_prog_mem.mem[i] = 16'h0000;
    u_prog_mem.mem[0] = w0;
    u_prog_mem.mem[1] = w1;
    u_prog_mem.mem[2] = w2;
    u_prog_mem.mem[3] = w3;
    u_prog_mem.mem[ta] = tw;
  endtask
  // halt, restart at 0, run until standby; st holds status, rdat the pc
  task run(input logic [7:0] cv);
    nwe = 0;
    npz = 0;
    bus(1, 4'h0, 0);
    bus(1, 4'h4, 0);
    bus(1, 4'h0, {24'h0, cv | 8'h01});
    // standby is only left while running, so wake stands for the first run cycle
    wake <= 1;
    @(posedge i_clk);
    wake <= 0;
    rdat = 0;
    for (k = 0; k < 30 && rdat[12] !== 1'b1; k++) bus(0, 4'h8, 0);
    st = rdat;
    bus(0, 4'h4, 0);
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    prog(0, 0, 0, 0, 8, 0);
    repeat (3) @(posedge i_clk);
    rst_n <= 1;
    bus(0, 4'h0, 0);
    chk(rdat, 0, "ctrl reset");
    bus(1, 4'h2, 32'hffffffff);
    bus(0, 4'h2, 0);
    chk(rdat, 0, "unmapped");
    // a control write without its low byte lane is dropped
    be <= 4'he;
    bus(1, 4'h0, 32'h000000ff);
    be <= 4'hf;
    bus(0, 4'h0, 0);
    chk(rdat, 0, "ctrl lanes");
    // random bit ops, some on the timer register and on ports
    repeat (12) begin
      r = rnd();
      w = {r[13:12] == 2'd3 ? 4'h8 : 4'h7 + r[13:12], r[11:9], r[16] ? 9'h0d6 : r[8:0]};
      fd <= r[31:24];
      pin_lvl <= r[23:16];
      port <= r[17];
      c = {6'h0, r[18], 1'b0};
      prog(w, 16'h0003, 0, 0, 8, 0);
      run(c);
      chk(nwe, 1, "writes");
      chk(lwa, w[8:0], "write addr");
      chk(lwd, bitop(w[15:12], port ? pin_lvl : fd, w[11:9]), "write data");
      chk(npz, w[8:0] == 9'h0d6 && c[1], "prescaler");
      chk(rdat, 2, "sleep pc");
      chk(st[9:8], 2'b10, "sleep flags");
    end
    // skip over a two-word jump, or take it
    repeat (8) begin
      r = rnd();
      w = {3'b101, r[0], r[11:0]};
      fd <= r[31:24];
      pin_lvl <= r[23:16];
      port <= r[17];
      prog(w, 16'hef08, 16'hf000, 16'h0003, 8, 16'h0003);
      run(0);
      j = ((port ? pin_lvl[w[11:9]] : fd[w[11:9]]) ^ w[12]) ? 4 : 9;
      chk(rdat, j, "skip pc");
    end
    // every branch condition with random flags
    for (j = 0; j < 8; j++) begin
      r = rnd();
      c = {r[3:0], 4'h0};
      prog({5'b11100, j[2:0], 8'h02}, 16'h0003, 0, 16'h0003, 8, 0);
      run(c);
      chk(rdat, taken(j[2:0], c[7:4]) ? 4 : 2, "branch pc");
    end
    // corner: bit set on the timer register with the prescaler assigned
    fd <= 8'h00;
    port <= 0;
    prog(16'h84d6, 16'h0003, 0, 0, 8, 0);
    run(8'h02);
    chk(npz, 1, "timer prescaler");
    chk(lwd, 8'h04, "timer bit set");
    // unconditional branch over two words, no stack change
    prog(16'hd002, 16'h0003, 0, 16'h0003, 8, 0);
    run(0);
    chk(rdat, 4, "bra pc");
    chk(st[20:16], 0, "bra depth");
    prog(16'h0005, 16'h0003, 0, 0, 8, 0);
    run(0);
    chk(st[20:16], 1, "push depth");
    bus(0, 4'hc, 0);
    chk(rdat, 1, "stack top");
    prog(16'h0006, 16'h0003, 0, 0, 8, 0);
    run(0);
    chk(st[20:16], 0, "pop depth");
    prog(16'hec08, 16'hf000, 16'h0003, 0, 8, 16'h0c5a);
    run(0);
    chk(rdat, 3, "call return pc");
    chk(st[7:0], 8'h5a, "working reg");
    prog(16'hd803, 16'h0003, 0, 0, 4, 16'h0010);
    run(0);
    chk(rdat, 2, "relative_call_op return pc");
    chk(st[11:10], 2'b11, "irq enables");
    summarize();
  end
endmodule // test_bit_and_control_op_decoder
bind bit_and_control_op_decoder bit_and_control_op_decoder_asserts #(
  .TIMER0_ADDR(TIMER0_ADDR)) u_asserts (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_pm_data(i_pm_data), .o_file_raddr(o_file_raddr), .i_file_rdata(i_file_rdata),
  .i_file_is_port(i_file_is_port), .i_pin_data(i_pin_data), .o_file_we(o_file_we),
  .o_file_waddr(o_file_waddr), .o_file_wdata(o_file_wdata),
  .o_prescaler_clr(o_prescaler_clr), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest));
`default_nettype wire
